// ===== rtl/dfem_pkg.sv
package dfem_pkg;
   // ---------------------------------------------------------------
   // object dictionary
   // ---------------------------------------------------------------
   localparam logic [15:0] IDX_FSW   = 16'h2320;
   localparam logic [15:0] IDX_MASK  = 16'h2321;
   localparam logic [15:0] IDX_HDL   = 16'h2322;
   localparam logic [7:0]  SUB_CNT   = 8'h00;
   localparam logic [7:0]  SUB_EMSK  = 8'h01;
   localparam logic [7:0]  SUB_FMSK  = 8'h02;
   localparam logic [7:0]  SUB_OMSK  = 8'h03;
   localparam logic [7:0]  SUB_DLY   = 8'h01;
   localparam logic [7:0]  SUB_DEV   = 8'h02;
   localparam logic [15:0] MASK_CNT  = 16'h0006;
   localparam logic [15:0] HDL_CNT   = 16'h0002;
   localparam logic [15:0] EMSK_RST  = 16'hFFFF;
   localparam logic [15:0] FMSK_RST  = 16'h0000;
   localparam logic [15:0] OMSK_RST  = 16'h0000;
   localparam logic [15:0] DLY_RST   = 16'h00C8;
   localparam logic [15:0] DEV_RST   = 16'h7530;
   localparam logic [15:0] COMM_LO   = 16'h1000;
   localparam logic [15:0] MFR_LO    = 16'h2000;
   localparam logic [15:0] PROF_LO   = 16'h6000;
   localparam logic [15:0] PROF_HI   = 16'h9FFF;
   localparam logic [1:0]  AREA_NONE = 2'h0;
   localparam logic [1:0]  AREA_COMM = 2'h1;
   localparam logic [1:0]  AREA_MFR  = 2'h2;
   localparam logic [1:0]  AREA_PROF = 2'h3;
   // ---------------------------------------------------------------
   // status bit positions and emergency codes
   // ---------------------------------------------------------------
   localparam int B_OCUR = 0, B_DEV = 1, B_OVOLT = 2, B_OTEMP = 3, B_MEM = 4;
   localparam int B_PASV = 6, B_OVR = 7, B_GUARD = 8, B_BOFF = 9;
   localparam int B_CONV = 11, B_SW = 12, B_PLONG = 13, B_PSHORT = 14;
   localparam logic [15:0] SERIOUS_MASK = 16'h0380;
   localparam logic [15:0] COMM_MASK    = 16'h03C0;
   localparam logic [15:0] EC_RESET = 16'h0000;
   localparam logic [15:0] EC_OVR   = 16'h8110;
   localparam logic [15:0] EC_PASV  = 16'h8120;
   localparam logic [15:0] EC_GUARD = 16'h8130;
   localparam logic [15:0] EC_BOFF  = 16'h8140;
   localparam logic [15:0] EC_OCUR  = 16'h2310;
   localparam logic [15:0] EC_DEV   = 16'h8400;
   localparam logic [15:0] EC_OVOLT = 16'h3210;
   localparam logic [15:0] EC_OTEMP = 16'h4210;
   localparam logic [15:0] EC_MEM   = 16'h5530;
   localparam logic [15:0] EC_SW    = 16'h6100;
   localparam logic [15:0] EC_PDO   = 16'h8210;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_NS       = 8;
   localparam int DLY_UNIT_NS  = 10000000;
   localparam int LIFE_UNIT_NS = 1000000;
   localparam int OVR_EMCY_NS  = 100000;
   localparam int DLY_UNIT_CYC = DLY_UNIT_NS / CLK_NS;
   localparam int LIFE_CYC     = LIFE_UNIT_NS / CLK_NS;
   localparam int OVR_CYC      = OVR_EMCY_NS / CLK_NS;
   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic        req;
      logic        wr;
      logic [15:0] idx;
      logic [7:0]  sub;
      logic [15:0] wdata;
   } dfem_obj_req_t;
   typedef struct packed {
      logic        ack;
      logic        err;
      logic [1:0]  area;
      logic [15:0] rdata;
   } dfem_obj_rsp_t;
   typedef struct packed {
      logic rx_overrun;
      logic err_passive;
      logic bus_off;
      logic rx_valid;
      logic guard_req;
      logic hb_timeout;
      logic [15:0] life_ms;
   } dfem_link_t;
   typedef struct packed {
      logic ocur;
      logic ovolt;
      logic otemp;
      logic mem;
      logic conv;
      logic sw;
      logic signed [31:0] act_speed;
      logic signed [31:0] tgt_speed;
   } dfem_drv_t;
   typedef struct packed {
      logic rx;
      logic too_long;
      logic too_short;
   } dfem_pdo_t;
   typedef struct packed {
      logic        valid;
      logic [15:0] code;
   } dfem_emcy_t;
   typedef struct packed {
      logic [15:0] fsw, emsk, fmsk, omsk, dly, dev, pend;
      logic        rst_pend;
      logic        pasv_q;
      logic [2:0][15:0] fcnt;
      logic [31:0] tick, ms, ovr;
      logic [15:0] life;
      dfem_obj_rsp_t rsp;
      dfem_emcy_t  emcy;
      logic        preop;
   } dfem_state_t;
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [15:0] dfem_code_f(input int b);
      unique case (b)
         B_OCUR:           dfem_code_f = EC_OCUR;
         B_DEV:            dfem_code_f = EC_DEV;
         B_OVOLT:          dfem_code_f = EC_OVOLT;
         B_OTEMP:          dfem_code_f = EC_OTEMP;
         B_MEM:            dfem_code_f = EC_MEM;
         B_PASV:           dfem_code_f = EC_PASV;
         B_OVR:            dfem_code_f = EC_OVR;
         B_GUARD:          dfem_code_f = EC_GUARD;
         B_BOFF:           dfem_code_f = EC_BOFF;
         B_PLONG, B_PSHORT: dfem_code_f = EC_PDO;
         default:          dfem_code_f = EC_SW;
      endcase
   endfunction : dfem_code_f
endpackage : dfem_pkg

// ===== rtl/dfem_top.sv
`timescale 1ns/100ps
`default_nettype none
module dfem_top import dfem_pkg::*; #(
   parameter int TICK_CYC  = DLY_UNIT_CYC,
   parameter int MS_CYC    = LIFE_CYC,
   parameter int OVR_DLY   = OVR_CYC
) (
   // clock and reset
   input  wire logic          I_SYS_CLK,
   input  wire logic          I_RESET,
   // object access
   input  wire dfem_obj_req_t I_OBJ,
   output dfem_obj_rsp_t      O_OBJ,
   // fault sources
   input  wire dfem_link_t    I_LINK,
   input  wire dfem_drv_t     I_DRV,
   input  wire dfem_pdo_t     I_PDO,
   // reactions
   output logic               O_PDO_ACCEPT,
   output dfem_emcy_t         O_EMCY,
   output logic               O_NMT_PREOP,
   output logic               O_ERR_COMM,
   output logic               O_FAULT_REACT,
   output logic               O_FAULT_PIN,
   output logic [15:0]        O_FSW
);
   if (TICK_CYC < 2 || MS_CYC < 2 || OVR_DLY < 16) begin : g_chk
      $error("dfem_top: timing parameters too small");
   end

   dfem_state_t s_r, s_nxt;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic        tick_p;
      logic        ms_p;
      logic [2:0]  cond;
      logic [2:0]  flt;
      logic [32:0] diff;
      logic        guard_to;
      logic [15:0] f;
      logic [15:0] rise;
      logic [15:0] elig;
      logic [15:0] sel;
      int          bi;
      tick_p   = 1'b0;
      ms_p     = 1'b0;
      cond     = '0;
      flt      = '0;
      diff     = '0;
      guard_to = 1'b0;
      f        = '0;
      rise     = '0;
      elig     = '0;
      sel      = '0;
      bi       = 0;
      s_nxt    = s_r;
      s_nxt.rsp.ack  = 1'b0;
      s_nxt.rsp.err  = 1'b0;
      s_nxt.emcy     = '0;
      s_nxt.preop    = 1'b0;
      tick_p     = (s_r.tick == 32'(TICK_CYC - 1));
      ms_p       = (s_r.ms == 32'(MS_CYC - 1));
      s_nxt.tick = tick_p ? '0 : s_r.tick + 32'h0000_0001;
      s_nxt.ms   = ms_p ? '0 : s_r.ms + 32'h0000_0001;
      diff = 33'(I_DRV.act_speed) - 33'(I_DRV.tgt_speed);
      if (diff[32]) begin
         diff = 33'h0_0000_0000 - diff;
      end
      cond[0] = I_DRV.ocur;
      cond[1] = (diff > {17'h0_0000, s_r.dev});
      cond[2] = I_DRV.ovolt;
      for (int k = 0; k < 3; k++) begin
         if (!cond[k]) begin
            s_nxt.fcnt[k] = '0;
         end else if (tick_p && s_r.fcnt[k] != 16'hFFFF) begin
            s_nxt.fcnt[k] = s_r.fcnt[k] + 16'h0001;
         end
         flt[k] = cond[k] && (s_r.fcnt[k] >= s_r.dly);
      end
      if (I_LINK.guard_req || I_LINK.life_ms == 16'h0000) begin
         s_nxt.life = '0;
      end else if (ms_p && s_r.life != 16'hFFFF) begin
         s_nxt.life = s_r.life + 16'h0001;
      end
      guard_to = (I_LINK.life_ms != 16'h0000) && (s_r.life >= I_LINK.life_ms);
      // status word
      f[B_OCUR]   = flt[0];
      f[B_DEV]    = flt[1];
      f[B_OVOLT]  = flt[2];
      f[B_OTEMP]  = I_DRV.otemp;
      f[B_MEM]    = I_DRV.mem;
      f[B_PASV]   = I_LINK.err_passive;
      f[B_OVR]    = s_r.fsw[B_OVR] | I_LINK.rx_overrun;
      f[B_GUARD]  = s_r.fsw[B_GUARD] | guard_to | I_LINK.hb_timeout;
      f[B_BOFF]   = s_r.fsw[B_BOFF] | (I_LINK.bus_off & I_LINK.rx_valid);
      f[B_CONV]   = I_DRV.conv;
      f[B_SW]     = I_DRV.sw;
      f[B_PLONG]  = I_PDO.rx ? I_PDO.too_long : s_r.fsw[B_PLONG];
      f[B_PSHORT] = I_PDO.rx ? I_PDO.too_short : s_r.fsw[B_PSHORT];
      s_nxt.fsw   = f;
      rise        = f & ~s_r.fsw;
      s_nxt.preop = |(rise & SERIOUS_MASK);
      // emergency queue
      if (rise[B_OVR]) begin
         s_nxt.ovr = 32'(OVR_DLY);
      end else if (s_r.ovr != '0) begin
         s_nxt.ovr = s_r.ovr - 32'h0000_0001;
      end
      elig = s_r.pend;
      if (s_r.ovr != '0) begin
         elig[B_OVR] = 1'b0;
      end
      for (int k = 15; k >= 0; k--) begin
         if (elig[k]) begin
            bi = k;
         end
      end
      s_nxt.pasv_q = I_LINK.err_passive;
      if (s_r.rst_pend) begin
         s_nxt.emcy.valid = 1'b1;
         s_nxt.emcy.code  = EC_RESET;
      end else if (elig != '0) begin
         sel[bi]          = 1'b1;
         s_nxt.emcy.valid = 1'b1;
         s_nxt.emcy.code  = dfem_code_f(bi);
      end
      s_nxt.rst_pend = (s_r.pasv_q & ~I_LINK.err_passive);
      s_nxt.pend = (s_r.pend & ~sel) | (rise & s_r.emsk);
      // object access
      if (I_OBJ.req) begin
         s_nxt.rsp.ack   = 1'b1;
         s_nxt.rsp.rdata = '0;
         if (I_OBJ.idx >= PROF_LO && I_OBJ.idx <= PROF_HI) begin
            s_nxt.rsp.area = AREA_PROF;
         end else if (I_OBJ.idx >= MFR_LO && I_OBJ.idx < PROF_LO) begin
            s_nxt.rsp.area = AREA_MFR;
         end else if (I_OBJ.idx >= COMM_LO && I_OBJ.idx < MFR_LO) begin
            s_nxt.rsp.area = AREA_COMM;
         end else begin
            s_nxt.rsp.area = AREA_NONE;
         end
         s_nxt.rsp.err = 1'b0;
         unique case ({I_OBJ.idx, I_OBJ.sub})
            {IDX_FSW, SUB_CNT}: begin
               s_nxt.rsp.rdata = s_r.fsw;
               s_nxt.rsp.err   = I_OBJ.wr;
            end
            {IDX_MASK, SUB_CNT}: begin
               s_nxt.rsp.rdata = MASK_CNT;
               s_nxt.rsp.err   = I_OBJ.wr;
            end
            {IDX_MASK, SUB_EMSK}: begin
               s_nxt.rsp.rdata = s_r.emsk;
               if (I_OBJ.wr) s_nxt.emsk = I_OBJ.wdata;
            end
            {IDX_MASK, SUB_FMSK}: begin
               s_nxt.rsp.rdata = s_r.fmsk;
               if (I_OBJ.wr) begin
                  s_nxt.fmsk = I_OBJ.wdata;
                  s_nxt.emsk = s_r.emsk | I_OBJ.wdata;
               end
            end
            {IDX_MASK, SUB_OMSK}: begin
               s_nxt.rsp.rdata = s_r.omsk;
               if (I_OBJ.wr) s_nxt.omsk = I_OBJ.wdata;
            end
            {IDX_HDL, SUB_CNT}: begin
               s_nxt.rsp.rdata = HDL_CNT;
               s_nxt.rsp.err   = I_OBJ.wr;
            end
            {IDX_HDL, SUB_DLY}: begin
               s_nxt.rsp.rdata = s_r.dly;
               if (I_OBJ.wr) s_nxt.dly = I_OBJ.wdata;
            end
            {IDX_HDL, SUB_DEV}: begin
               s_nxt.rsp.rdata = s_r.dev;
               if (I_OBJ.wr) s_nxt.dev = I_OBJ.wdata;
            end
            default: s_nxt.rsp.err = 1'b1;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RESET) begin
         s_r      <= '0;
         s_r.emsk <= EMSK_RST;
         s_r.fmsk <= FMSK_RST;
         s_r.omsk <= OMSK_RST;
         s_r.dly  <= DLY_RST;
         s_r.dev  <= DEV_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign O_OBJ         = s_r.rsp;
   assign O_EMCY        = s_r.emcy;
   assign O_NMT_PREOP   = s_r.preop;
   assign O_FSW         = s_r.fsw;
   assign O_ERR_COMM    = |(s_r.fsw & COMM_MASK);
   assign O_FAULT_REACT = |(s_r.fsw & s_r.fmsk);
   assign O_FAULT_PIN   = |(s_r.fsw & s_r.omsk);
   assign O_PDO_ACCEPT  = I_PDO.rx & ~I_PDO.too_short;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (I_RESET);

   a_ovr_set : assert property (
      I_LINK.rx_overrun |=> O_FSW[B_OVR] && O_ERR_COMM)
      else $error("overrun not flagged");
   a_ovr_late : assert property (
      $rose(O_FSW[B_OVR]) |-> (!(O_EMCY.valid && O_EMCY.code == EC_OVR))[*8])
      else $error("overrun emergency too early");
   a_ovr_wait : assert property (
      s_r.ovr != 32'h0000_0000 |=> !(O_EMCY.valid && O_EMCY.code == EC_OVR))
      else $error("overrun emergency before delay");
   a_reset_keep : assert property (
      O_FSW[B_OVR] && O_EMCY.valid && O_EMCY.code == EC_RESET |=> O_FSW[B_OVR])
      else $error("error reset cleared overrun");
   a_serious_hold : assert property (
      (O_FSW & SERIOUS_MASK & $past(O_FSW)) == (SERIOUS_MASK & $past(O_FSW)))
      else $error("serious bit cleared");
   a_passive_set : assert property (
      $rose(I_LINK.err_passive) |=> O_FSW[B_PASV] && O_ERR_COMM)
      else $error("passive not flagged");
   a_passive_clr : assert property (
      $fell(I_LINK.err_passive) |=> !O_FSW[B_PASV])
      else $error("passive bit not withdrawn");
   a_active_reset : assert property (
      $fell(I_LINK.err_passive) |=> ##1 O_EMCY.valid && O_EMCY.code == EC_RESET)
      else $error("error reset emergency missing");
   a_busoff_rec : assert property (
      I_LINK.bus_off && I_LINK.rx_valid |=> O_FSW[B_BOFF])
      else $error("bus-off recovery not flagged");
   a_hb_guard : assert property (
      I_LINK.hb_timeout |=> O_FSW[B_GUARD])
      else $error("heartbeat timeout not flagged");
   a_guard_off : assert property (
      !O_FSW[B_GUARD] && I_LINK.life_ms == 16'h0000 && !I_LINK.hb_timeout |=> !O_FSW[B_GUARD])
      else $error("guarding error with zero life time");
   a_fmsk_copy : assert property (
      I_OBJ.req && I_OBJ.wr && I_OBJ.idx == IDX_MASK && I_OBJ.sub == SUB_FMSK
      |=> (s_r.emsk & $past(I_OBJ.wdata)) == $past(I_OBJ.wdata))
      else $error("fault mask not copied");
   a_emsk_keep : assert property (
      I_OBJ.req && I_OBJ.wr && I_OBJ.idx == IDX_MASK && I_OBJ.sub == SUB_FMSK
      |=> (s_r.emsk & $past(s_r.emsk)) == $past(s_r.emsk))
      else $error("emergency mask bits lost");
   a_pin_quiet : assert property (
      s_r.omsk == 16'h0000 |-> !O_FAULT_PIN)
      else $error("fault pin with empty mask");
   a_short_pdo : assert property (
      I_PDO.rx && I_PDO.too_short |-> !O_PDO_ACCEPT ##1 O_FSW[B_PSHORT])
      else $error("short pdo accepted");
   a_pdo_long : assert property (
      I_PDO.rx && I_PDO.too_long && !I_PDO.too_short |-> O_PDO_ACCEPT ##1 O_FSW[B_PLONG])
      else $error("long pdo not processed");
   a_ocur_wait : assert property (
      I_DRV.ocur && s_r.fcnt[0] < s_r.dly |=> !O_FSW[B_OCUR])
      else $error("overcurrent reported before delay");
   a_ocur_gone : assert property (
      !I_DRV.ocur |=> !O_FSW[B_OCUR])
      else $error("overcurrent bit without source");
   a_dev_flag : assert property (
      I_DRV.act_speed == I_DRV.tgt_speed |=> !O_FSW[B_DEV])
      else $error("deviation flagged at zero difference");
   a_preop_req : assert property (
      $rose(O_FSW[B_GUARD]) |-> O_NMT_PREOP)
      else $error("no pre-operational request");
   a_preop_only : assert property (
      O_NMT_PREOP |-> |(O_FSW & SERIOUS_MASK))
      else $error("pre-operational request without serious error");
   a_obj_ack : assert property (
      I_OBJ.req |=> O_OBJ.ack)
      else $error("object access not answered");
   a_fsw_ro : assert property (
      I_OBJ.req && I_OBJ.wr && I_OBJ.idx == IDX_FSW && I_OBJ.sub == SUB_CNT
      |=> O_OBJ.err)
      else $error("status word write not refused");
   a_area_comm : assert property (
      I_OBJ.req && I_OBJ.idx >= COMM_LO && I_OBJ.idx < MFR_LO |=> O_OBJ.area == AREA_COMM)
      else $error("communication area not decoded");

   c_overrun : cover property (s_r.ovr == 32'h0000_0001
      ##[1:4] O_EMCY.valid && O_EMCY.code == EC_OVR);
   c_passive : cover property ($rose(O_FSW[B_PASV]) ##[1:50] $fell(O_FSW[B_PASV]));
   c_fmsk_wr : cover property (I_OBJ.req && I_OBJ.wr && I_OBJ.sub == SUB_FMSK);
   c_react   : cover property ($rose(O_FAULT_REACT));
endmodule : dfem_top
`default_nettype wire

// ===== testbench/dfem_master.sv
`timescale 1ns/100ps
`default_nettype none
module dfem_master import dfem_pkg::*; (
   // clock
   input  wire logic          i_clk,
   // object access
   output var dfem_obj_req_t  o_obj
);
   initial o_obj = '0;
   // ---------------------------------------------------------------
   // one access a call; fields scrambled once the request is gone
   // ---------------------------------------------------------------
   task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                         input logic [15:0] wdata, input int gap);
      repeat (gap) @(negedge i_clk);
      @(negedge i_clk);
      o_obj = '{req: 1'b1, wr: wr, idx: idx, sub: sub, wdata: wdata};
      @(negedge i_clk);
      o_obj = '{req: 1'b0, wr: ~wr, idx: ~idx, sub: ~sub, wdata: ~wdata};
   endtask : access
endmodule : dfem_master
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top import dfem_pkg::*;;
   typedef struct packed {
      logic        err;
      logic [1:0]  area;
      logic [15:0] d;
      logic        chk;
   } dfem_exp_t;
   logic          clk = 1'b0;
   logic          rst = 1'b1;
   dfem_obj_req_t obj;
   dfem_obj_rsp_t rsp;
   dfem_link_t    lnk = '0;
   dfem_drv_t     drv = '0;
   dfem_pdo_t     pdo = '0;
   dfem_emcy_t    emcy;
   dfem_exp_t     e;
   logic          acc, preop, ecomm, react, pin;
   logic [15:0]   fsw;
   int            bad_count = 0, n_compared = 0, seed = 51, cyc = 0, ovr_cyc = 0, n_preop = 0;
   dfem_exp_t     oq[$];
   logic [15:0]   eq[$];
   logic [15:0]   r_idx [8] = '{IDX_FSW, IDX_MASK, IDX_MASK, IDX_MASK,
                                IDX_MASK, IDX_HDL, IDX_HDL, IDX_HDL};
   logic [7:0]    r_sub [8] = '{SUB_CNT, SUB_CNT, SUB_EMSK, SUB_FMSK,
                                SUB_OMSK, SUB_CNT, SUB_DLY, SUB_DEV};
   logic [15:0]   r_val [8] = '{16'h0000, MASK_CNT, EMSK_RST, FMSK_RST,
                                OMSK_RST, HDL_CNT, DLY_RST, DEV_RST};
   logic [15:0]   d_idx [7] = '{16'h0FFF, 16'h1000, 16'h1FFF, 16'h5FFF,
                                16'h6000, 16'h9FFF, 16'hA000};
   logic [1:0]    d_ar  [7] = '{AREA_NONE, AREA_COMM, AREA_COMM, AREA_MFR,
                                AREA_PROF, AREA_PROF, AREA_NONE};
   always #4 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   dfem_top #(.TICK_CYC(10), .MS_CYC(4), .OVR_DLY(20)) dut (
      .I_SYS_CLK(clk), .I_RESET(rst), .I_OBJ(obj), .O_OBJ(rsp), .I_LINK(lnk), .I_DRV(drv),
      .I_PDO(pdo), .O_PDO_ACCEPT(acc), .O_EMCY(emcy), .O_NMT_PREOP(preop), .O_ERR_COMM(ecomm),
      .O_FAULT_REACT(react), .O_FAULT_PIN(pin), .O_FSW(fsw));
   dfem_master mst (.i_clk(clk), .o_obj(obj));
   // ---------------------------------------------------------------
   // comparison and closing
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   task automatic op(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                     input logic [15:0] wd, input logic err, input logic [1:0] ar,
                     input logic [15:0] rd, input logic chk);
      oq.push_back('{err, ar, rd, chk});
      mst.access(wr, idx, sub, wd, $random(seed) & 1);
   endtask : op
   task automatic pdo_rx(input logic l, input logic s, input logic a, input logic [15:0] f);
      @(negedge clk);
      pdo = '{rx: 1'b1, too_long: l, too_short: s};
      #1 check("accept", acc, a);
      @(negedge clk);
      pdo = '0;
      tick(3);
      check("fsw pdo", fsw, f);
   endtask : pdo_rx
   // ---------------------------------------------------------------
   // monitor: responses and emergencies against the notes
   // ---------------------------------------------------------------
   always @(negedge clk) begin
      if (!rst && rsp.ack === 1'b1) begin
         if (oq.size() == 0) check("spare ack", 1'b1, 1'b0);
         else begin
            e = oq.pop_front();
            check("obj err", rsp.err, e.err);
            check("obj area", rsp.area, e.area);
            if (e.chk) check("obj data", rsp.rdata, e.d);
         end
      end
      if (!rst && emcy.valid === 1'b1) begin
         if (eq.size() == 0) check("spare emcy", emcy.code, 16'hFFFF);
         else check("emcy code", emcy.code, eq.pop_front());
         if (emcy.code === EC_OVR) check("ovr late", (cyc - ovr_cyc) >= 20, 1'b1);
      end
      if (!rst && preop === 1'b1) n_preop++;
   end
   initial begin
      #(8 * 6000);
      bad_count++;
      results();
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      tick(6);
      rst = 1'b0;
      check("fsw reset", fsw, 16'h0000);
      check("pin reset", pin, 1'b0);
      for (int i = 0; i < 8; i++) op(0, r_idx[i], r_sub[i], 0, 0, AREA_MFR, r_val[i], 1);
      for (int i = 0; i < 7; i++) op(0, d_idx[i], 8'h00, 0, 1, d_ar[i], 0, 0);
      op(1, IDX_FSW, SUB_CNT, 16'hFFFF, 1, AREA_MFR, 0, 0);
      op(1, IDX_MASK, SUB_CNT, 16'h0001, 1, AREA_MFR, 0, 0);
      op(0, IDX_MASK, 8'h04, 0, 1, AREA_MFR, 0, 0);
      op(0, IDX_MASK, SUB_CNT, 0, 0, AREA_MFR, MASK_CNT, 1);
      op(1, IDX_MASK, SUB_EMSK, 16'h0000, 0, AREA_MFR, EMSK_RST, 1);
      op(1, IDX_MASK, SUB_FMSK, 16'h0008, 0, AREA_MFR, FMSK_RST, 1);
      op(1, IDX_MASK, SUB_OMSK, 16'h0010, 0, AREA_MFR, OMSK_RST, 1);
      op(0, IDX_MASK, SUB_EMSK, 0, 0, AREA_MFR, 16'h0008, 1);
      eq.push_back(EC_OTEMP);
      drv.otemp = 1'b1;
      tick(3);
      check("fsw temp", fsw, 16'h0008);
      check("react", react, 1'b1);
      check("pin off", pin, 1'b0);
      drv.mem = 1'b1;
      tick(3);
      check("pin on", pin, 1'b1);
      drv.otemp = 1'b0;
      drv.mem = 1'b0;
      tick(3);
      check("fsw clear", fsw, 16'h0000);
      check("react off", react, 1'b0);
      op(1, IDX_MASK, SUB_EMSK, 16'hFFFF, 0, AREA_MFR, 16'h0008, 1);
      eq.push_back(EC_SW);
      drv.conv = 1'b1;
      tick(3);
      check("fsw conv", fsw, 16'h0800);
      drv.conv = 1'b0;
      drv.sw = 1'b1;
      eq.push_back(EC_SW);
      tick(3);
      check("fsw sw", fsw, 16'h1000);
      drv.sw = 1'b0;
      op(1, IDX_HDL, SUB_DLY, 16'h0003, 0, AREA_MFR, DLY_RST, 1);
      op(1, IDX_HDL, SUB_DEV, 16'h0064, 0, AREA_MFR, DEV_RST, 1);
      eq.push_back(EC_OCUR);
      eq.push_back(EC_OVOLT);
      drv.ocur = 1'b1;
      drv.ovolt = 1'b1;
      tick(15);
      check("fsw early", fsw, 16'h0000);
      tick(30);
      check("fsw late", fsw, 16'h0005);
      drv.ocur = 1'b0;
      drv.ovolt = 1'b0;
      drv.tgt_speed = $random(seed) % 1000000;
      drv.act_speed = drv.tgt_speed + 100;
      tick(45);
      check("fsw dev edge", fsw, 16'h0000);
      eq.push_back(EC_DEV);
      drv.act_speed = drv.tgt_speed - 101;
      tick(45);
      check("fsw dev", fsw, 16'h0002);
      drv.act_speed = drv.tgt_speed;
      eq.push_back(EC_PDO);
      pdo_rx(1, 0, 1, 16'h2000);
      eq.push_back(EC_PDO);
      pdo_rx(0, 1, 0, 16'h4000);
      pdo_rx(0, 0, 1, 16'h0000);
      eq.push_back(EC_OVR);
      lnk.rx_overrun = 1'b1;
      ovr_cyc = cyc;
      tick(1);
      lnk.rx_overrun = 1'b0;
      tick(2);
      check("fsw ovr", fsw, 16'h0080);
      check("comm err", ecomm, 1'b1);
      tick(40);
      eq.push_back(EC_PASV);
      lnk.err_passive = 1'b1;
      tick(8);
      check("fsw pasv", fsw, 16'h00C0);
      eq.push_back(EC_RESET);
      lnk.err_passive = 1'b0;
      tick(5);
      check("fsw active", fsw, 16'h0080);
      lnk.bus_off = 1'b1;
      tick(3);
      check("fsw boff", fsw, 16'h0080);
      eq.push_back(EC_BOFF);
      lnk.rx_valid = 1'b1;
      tick(1);
      lnk.rx_valid = 1'b0;
      lnk.bus_off = 1'b0;
      tick(3);
      check("fsw recov", fsw, 16'h0280);
      lnk.life_ms = 16'h0003;
      repeat (8) begin
         lnk.guard_req = 1'b1;
         tick(1);
         lnk.guard_req = 1'b0;
         tick(4);
      end
      check("fsw guarded", fsw, 16'h0280);
      eq.push_back(EC_GUARD);
      tick(30);
      check("fsw guard", fsw, 16'h0380);
      op(1, IDX_MASK, SUB_OMSK, 16'hFFFF, 0, AREA_MFR, 16'h0010, 1);
      op(0, IDX_FSW, SUB_CNT, 0, 0, AREA_MFR, 16'h0380, 1);
      tick(10);
      check("pin all", pin, 1'b1);
      check("react none", react, 1'b0);
      // restart clears the sticky bits; a heartbeat timeout then sets bit 8 again
      rst = 1'b1;
      tick(2);
      rst = 1'b0;
      check("fsw restart", fsw, 16'h0000);
      check("pin restart", pin, 1'b0);
      eq.push_back(EC_GUARD);
      lnk.hb_timeout = 1'b1;
      tick(1);
      lnk.hb_timeout = 1'b0;
      tick(3);
      check("fsw hb", fsw, 16'h0100);
      check("preop count", n_preop, 16'd4);
      check("emcy left", eq.size(), 16'd0);
      check("acks left", oq.size(), 16'd0);
      results();
   end
endmodule : tb_top
`default_nettype wire
